//--- dv/sdh_card_model.sv
// Card-side model that answers issued commands and clocks the init preamble.
`timescale 1ns/10ps
module sdh_card_model
   import sdh_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic cmd_line_oe,
   input wire logic cmd_issue_valid,
   input wire sdh_issue_t cmd_issue,
   input wire logic [3:0] lat,
   output logic card_clk,
   output logic cmd_sent,
   output logic resp_valid,
   output logic [5:0] resp_index,
   output logic [127:0] resp_data
);
   sdh_issue_t cur;
   logic [4:0] cnt;
   logic [1:0] ph;
   // The card clock runs only while the preamble is driven and rests low otherwise.
   initial begin
      card_clk = 1'b0;
      #0.3;
      forever #62.5 card_clk = cmd_line_oe ? ~card_clk : 1'b0;
   end
   // Handshake lat+1 cycles after the issue; reply lines scramble while no reply is valid.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {cnt, ph, cmd_sent, resp_valid, resp_index, resp_data} <= '0;
      end else begin
         cmd_sent <= 1'b0;
         resp_valid <= 1'b0;
         resp_index <= ~resp_index;
         resp_data <= ~resp_data;
         if (cmd_issue_valid) begin
            cur <= cmd_issue;
            cnt <= {1'b0, lat} + 5'h1;
            ph <= 2'h1;
         end else if (cnt > 5'h1) begin
            cnt <= cnt - 5'h1;
         end else if (ph == 2'h1) begin
            cmd_sent <= 1'b1;
            cnt <= {1'b0, lat} + 5'h1;
            ph <= cur.resp_exp ? 2'h2 : 2'h0;
         end else if (ph == 2'h2) begin
            resp_valid <= 1'b1;
            resp_index <= cur.index;
            resp_data <= {cur.arg + 32'h3, cur.arg + 32'h2, cur.arg + 32'h1, cur.arg};
            ph <= 2'h0;
         end
      end
   end
endmodule

//--- dv/sdh_regs_checker.sv
// Concurrent checks on the ports of the card host register bank.
`timescale 1ns/10ps
`include "sdh_defines.svh"
module sdh_regs_checker
   import sdh_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic cmd_line_out,
   input wire logic cmd_line_oe,
   input wire logic [1:0] card_rst_n,
   input wire sdh_issue_t cmd_issue,
   input wire logic cmd_issue_valid,
   input wire logic [2:0] dma_burst_code,
   input wire logic internal_dma_on,
   input wire logic fixed_burst_select,
   input wire logic dma_soft_reset,
   input wire logic descriptor_resume,
   input wire logic irq
);
   logic wr;
   logic rd;
   logic [17:0] msk_ff;
   // Access-phase decode of the bus.
   assign wr = psel & penable & pready & pwrite;
   assign rd = psel & penable & pready & ~pwrite;
   // Shadow of the enable mask, taken from bus writes.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         msk_ff <= 18'h0;
      end else if (wr && paddr == `SDH_A_INTMASK) begin
         msk_ff <= pwdata[17:0];
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_card_reset: assert property (wr && paddr == `SDH_A_RSTCARD |=> card_rst_n == $past(pwdata[1:0]))
      else $error("card reset bits differ from write");
   a_soft_reset: assert property (wr && paddr == `SDH_A_BMOD && pwdata[0] |=> dma_soft_reset ##1 !dma_soft_reset)
      else $error("soft reset is not a one cycle pulse");
   a_dma_mode: assert property (wr && paddr == `SDH_A_BMOD && !pwdata[0] |=>
      internal_dma_on == $past(pwdata[7]) && fixed_burst_select == $past(pwdata[1]))
      else $error("dma mode bits differ from write");
   a_burst_code: assert property (wr && paddr == `SDH_A_FIFO_THRESHOLD_CONTROL |=> dma_burst_code == $past(pwdata[30:28]))
      else $error("burst code differs from write");
   a_poll_resume: assert property (wr && paddr == `SDH_A_POLL |=> descriptor_resume ##1 !descriptor_resume)
      else $error("poll write gave no resume pulse");
   a_init_line: assert property (cmd_line_oe |-> cmd_line_out && !cmd_issue_valid)
      else $error("preamble not high or command sent during it");
   a_init_hold: assert property ($rose(cmd_line_oe) |-> cmd_line_oe [*8])
      else $error("preamble ended too early");
   a_issue_nodata: assert property (cmd_issue_valid && !cmd_issue.data_exp |->
      !cmd_issue.write && !cmd_issue.stream && !cmd_issue.auto_stop)
      else $error("data fields set without data phase");
   a_mask_read: assert property (rd && paddr == `SDH_A_MINTSTS |-> (prdata[17:0] & ~msk_ff) == 18'h0)
      else $error("masked status shows a disabled bit");
   a_irq_masked: assert property (msk_ff == 18'h0 && $past(msk_ff) == 18'h0 |-> !irq)
      else $error("interrupt high with all events masked");
   c_init: cover property ($fell(cmd_line_oe));
   c_long: cover property (cmd_issue_valid && cmd_issue.resp_long);
   c_irq: cover property (irq);
endmodule
bind sdh_regs sdh_regs_checker sdh_regs_checker_inst (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .pwdata, .prdata, .pready, .cmd_line_out, .cmd_line_oe, .card_rst_n, .cmd_issue,
   .cmd_issue_valid, .dma_burst_code, .internal_dma_on, .fixed_burst_select, .dma_soft_reset,
   .descriptor_resume, .irq);

//--- dv/sdh_regs_tb_top.sv
// Self-checking bench of the card host register bank.
`timescale 1ns/10ps
`include "sdh_defines.svh"
`define CHK(g, x) begin \
   n_tests++; \
   if ((g) !== (x)) begin \
      error_cnt++; \
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x); \
   end \
end
module sdh_regs_tb_top;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, card_clk, card_data0, card_data3;
   logic cmd_line_out, cmd_line_oe, cmd_issue_valid, cmd_sent, resp_valid, data_engine_active;
   logic end_of_packet, internal_dma_on, fixed_burst_select, dma_soft_reset, descriptor_resume, irq;
   logic [1:0] card_detect_n, card_wp, card_irq, card_rst_n;
   logic [2:0] dma_burst_code;
   logic [3:0] lat;
   logic [5:0] resp_index;
   logic [7:0] paddr;
   logic [12:0] fifo_count;
   logic [15:0] event_pulse;
   logic [31:0] pwdata, prdata, card_byte_count, host_byte_count, a, m, r, debounce_count;
   logic [127:0] resp_data;
   logic [64:0] e;
   logic [64:0] q[$];
   sdh_pkg::sdh_issue_t cmd_issue;
   int error_cnt, n_tests, cyc, ck_n, n_iss, ni;
   sdh_regs sdh_regs_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .card_clk, .card_data0, .card_data3, .card_detect_n, .card_wp, .card_irq,
      .cmd_line_out, .cmd_line_oe, .card_rst_n, .cmd_issue, .cmd_issue_valid, .cmd_sent,
      .resp_valid, .resp_index, .resp_data, .event_pulse, .data_engine_active, .fifo_count,
      .end_of_packet, .card_byte_count, .host_byte_count, .dma_rx_req(), .dma_tx_req(),
      .dma_single(), .dma_burst_code, .internal_dma_on, .fixed_burst_select, .dma_soft_reset,
      .descriptor_resume, .debounce_count, .irq);
   sdh_card_model sdh_card_model_inst (.pclk, .presetn, .cmd_line_oe, .cmd_issue_valid,
      .cmd_issue, .lat, .card_clk, .cmd_sent, .resp_valid, .resp_index, .resp_data);
   // Clock source.
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   // Counts issues, preamble clocks and cycles; cuts a hung run short.
   always @(posedge card_clk) if (cmd_line_oe) ck_n++;
   always @(posedge pclk) begin
      cyc++;
      if (cmd_issue_valid === 1'b1) n_iss++;
      if (cyc == 20000) begin
         error_cnt++;
         results();
      end
   end
   // Takes the oldest noted read result and compares it at the access edge.
   always @(posedge pclk) begin
      if (psel && penable && pready && !pwrite) begin
         e = q.pop_front();
         `CHK({pslverr, e[63:32], prdata & e[63:32]}, e)
      end
   end
   task results();
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [7:0] ad, input logic [31:0] d);
      apb(1'b1, ad, d);
   endtask
   task rd(input logic [7:0] ad, input logic [31:0] x, input logic [31:0] mk, input logic s = 0);
      q.push_back({s, mk, x & mk});
      apb(1'b0, ad, 32'h0);
   endtask
   task go(input logic [31:0] c);
      a = $urandom;
      ck_n = 0;
      wr(`SDH_A_CMDARG, a);
      wr(`SDH_A_CMD, c);
      @(posedge pclk iff cmd_issue_valid);
      `CHK({cmd_issue.index, cmd_issue.arg, cmd_issue.resp_exp, cmd_issue.resp_long}, {c[5:0], a, c[6], c[7]})
      `CHK({cmd_issue.crc_check, cmd_issue.stop_abort}, {c[8], c[14]})
      `CHK({cmd_issue.data_exp, cmd_issue.write, cmd_issue.stream, cmd_issue.auto_stop}, c[9] ? {c[9], c[10], c[11], c[12]} : 4'h0)
      if (c[15]) `CHK(ck_n, 80)
      @(posedge pclk iff (c[6] ? resp_valid : cmd_sent));
      repeat (3) @(posedge pclk);
   endtask
   // Main sequence.
   initial begin
      {psel, penable, pwrite, paddr, pwdata, card_data0, card_data3, card_irq, lat} = '0;
      {event_pulse, data_engine_active, fifo_count, end_of_packet, card_wp} = '0;
      {card_byte_count, host_byte_count} = '0;
      card_detect_n = 2'h3;
      presetn = 1'b0;
      r = $urandom(70);
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      for (int w = 0; w < 4; w++) rd(8'(48 + 4 * w), 32'h0, '1);
      rd(8'h70, 32'h0, '1, 1'b1);
      `CHK(card_rst_n, 2'h3)
      $display("reset test done");
      for (int l = 0; l < 2; l++) begin
         wr(`SDH_A_RINTSTS, 32'h4);
         r = $urandom;
         lat <= r[19:16];
         go({1'b1, 15'h0, 1'b0, r[14:8], l[0], 1'b1, r[5:0]});
         for (int w = 0; w < 4; w++) rd(8'(48 + 4 * w), (l || w == 0) ? a + w : 32'h0, '1);
         rd(`SDH_A_STATUS, {15'h0, r[5:0], 11'h0}, 32'h0001_F8F0);
         rd(`SDH_A_RINTSTS, 32'h4, 32'h4);
      end
      go(32'h8000_8000);
      data_engine_active <= 1'b1;
      go(32'h8000_0000);
      wr(`SDH_A_RINTSTS, '1);
      ni = n_iss;
      wr(`SDH_A_CMD, 32'h8000_2000);
      wr(`SDH_A_CMD, 32'h8000_0000);
      rd(`SDH_A_STATUS, 32'h200, 32'h200);
      `CHK(n_iss, ni)
      rd(`SDH_A_RINTSTS, 32'h1000, 32'h1000);
      data_engine_active <= 1'b0;
      @(posedge pclk iff cmd_sent);
      `CHK(n_iss, ni + 1)
      $display("command test done");
      wr(`SDH_A_FIFO_THRESHOLD_CONTROL, 32'h0014_0000);
      fifo_count <= 13'd10;
      wr(`SDH_A_RINTSTS, '1);
      r = $urandom;
      event_pulse <= r[15:0];
      card_irq <= 2'h3;
      @(posedge pclk);
      event_pulse <= 16'h0;
      repeat (4) @(posedge pclk);
      card_irq <= 2'h0;
      repeat (4) @(posedge pclk);
      rd(`SDH_A_RINTSTS, {14'h0, 2'h3, r[15:0]}, '1);
      m = $urandom;
      wr(`SDH_A_INTMASK, m);
      rd(`SDH_A_MINTSTS, {14'h0, 2'h3, r[15:0]} & m, '1);
      `CHK(irq, |({2'h3, r[15:0]} & m[17:0]))
      wr(`SDH_A_RINTSTS, m);
      rd(`SDH_A_RINTSTS, {14'h0, 2'h3, r[15:0]} & ~m, 32'h3FFFF);
      wr(`SDH_A_INTMASK, 32'h0);
      repeat (2) @(posedge pclk);
      `CHK(irq, 1'b0)
      fifo_count <= 13'd21;
      data_engine_active <= 1'b1;
      wr(`SDH_A_RINTSTS, '1);
      rd(`SDH_A_RINTSTS, 32'h20, 32'h30);
      fifo_count <= 13'd5;
      event_pulse <= 16'h0008;
      @(posedge pclk);
      event_pulse <= 16'h0000;
      wr(`SDH_A_RINTSTS, 32'h30);
      rd(`SDH_A_RINTSTS, 32'h8, 32'h38);
      wr(`SDH_A_CMD, 32'h0000_0400);
      fifo_count <= 13'd1;
      rd(`SDH_A_RINTSTS, 32'h0, 32'h30);
      end_of_packet <= 1'b1;
      rd(`SDH_A_RINTSTS, 32'h10, 32'h30);
      {end_of_packet, data_engine_active} <= 2'b00;
      $display("event test done");
      for (int i = 0; i < 4; i++) begin
         r = $urandom;
         {card_data3, card_data0} <= 2'(i);
         {card_wp, card_detect_n} <= r[3:0];
         card_byte_count <= r;
         host_byte_count <= ~r;
         repeat (4) @(posedge pclk);
         rd(`SDH_A_STATUS, {22'h0, ~i[0], i[1], 8'h0}, 32'h700);
         rd(`SDH_A_CDETECT, {30'h0, r[1:0]}, 32'h3);
         rd(`SDH_A_WRTPRT, {30'h0, r[3:2]}, 32'h3);
         rd(`SDH_A_TCBCNT, r, '1);
         rd(`SDH_A_TBBCNT, ~r, '1);
      end
      $display("line test done");
      for (int i = 0; i < 8; i++) begin
         wr(`SDH_A_FIFO_THRESHOLD_CONTROL, {1'b0, i[2:0], 28'h014_0000});
         rd(`SDH_A_BMOD, {21'h0, i[2:0], 8'h0}, 32'h700);
         `CHK(dma_burst_code, i[2:0])
      end
      wr(`SDH_A_BMOD, 32'h82);
      rd(`SDH_A_BMOD, 32'h82, 32'h83);
      wr(`SDH_A_BMOD, 32'h83);
      repeat (2) @(posedge pclk);
      `CHK({internal_dma_on, fixed_burst_select, dma_soft_reset}, 3'h0)
      r = $urandom;
      wr(`SDH_A_DEBNCE, r);
      wr(`SDH_A_USRID, ~r);
      `CHK(debounce_count, r)
      rd(`SDH_A_DEBNCE, r, '1);
      rd(`SDH_A_USRID, ~r, '1);
      wr(`SDH_A_POLL, $urandom);
      wr(`SDH_A_RSTCARD, 32'h1);
      @(posedge pclk);
      `CHK(card_rst_n, 2'h1)
      rd(`SDH_A_RSTCARD, 32'h1, 32'h3);
      $display("dma test done");
      results();
   end
endmodule

//--- verilog/sdh_defines.svh
// Register offsets, field positions, reset values and timing counts of the card host register bank.
`ifndef SDH_DEFINES_SVH
`define SDH_DEFINES_SVH
`define SDH_A_INTMASK 8'h24
`define SDH_A_CMDARG 8'h28
`define SDH_A_CMD 8'h2C
`define SDH_A_RESP0 8'h30
`define SDH_A_RESP1 8'h34
`define SDH_A_RESP2 8'h38
`define SDH_A_RESP3 8'h3C
`define SDH_A_MINTSTS 8'h40
`define SDH_A_RINTSTS 8'h44
`define SDH_A_STATUS 8'h48
`define SDH_A_FIFO_THRESHOLD_CONTROL 8'h4C
`define SDH_A_CDETECT 8'h50
`define SDH_A_WRTPRT 8'h54
`define SDH_A_TCBCNT 8'h5C
`define SDH_A_TBBCNT 8'h60
`define SDH_A_DEBNCE 8'h64
`define SDH_A_USRID 8'h68
`define SDH_A_RSTCARD 8'h78
`define SDH_A_BMOD 8'h80
`define SDH_A_POLL 8'h84
`define SDH_B_START 31
`define SDH_B_INIT 15
`define SDH_B_STOPAB 14
`define SDH_B_WAITPRV 13
`define SDH_B_AUTOSTOP 12
`define SDH_B_TMODE 11
`define SDH_B_WRITE 10
`define SDH_B_DATAEXP 9
`define SDH_B_CRCCHK 8
`define SDH_B_RLONG 7
`define SDH_B_REXP 6
`define SDH_E_CARDDET 0
`define SDH_E_CMDDONE 2
`define SDH_E_TXREQ 4
`define SDH_E_RXREQ 5
`define SDH_E_LOCKED 12
`define SDH_E_RTO 8
`define SDH_E_RESPERR 1
`define SDH_B_SWR 0
`define SDH_B_FB 1
`define SDH_B_DE 7
`define SDH_INIT_CLKS 7'd80
`define SDH_RST_CARDRST 2'h3
`define SDH_RST_WORD 32'h00000000
`define SDH_RST_DETECT 2'h3
`define SDH_EV_BITS 18
`endif

//--- verilog/sdh_pkg.sv
// Types shared by the card host register bank.
package sdh_pkg;
   typedef enum logic [3:0] {
      SDH_IDLE = 4'h0,
      SDH_INIT = 4'h1,
      SDH_TXST = 4'h2,
      SDH_RXST = 4'h7,
      SDH_NCC = 4'hE
   } sdh_cmd_state_t;
   typedef struct packed {
      logic [5:0] index;
      logic [31:0] arg;
      logic resp_exp;
      logic resp_long;
      logic crc_check;
      logic data_exp;
      logic write;
      logic stream;
      logic auto_stop;
      logic stop_abort;
      logic [4:0] card;
   } sdh_issue_t;
   typedef struct packed {
      logic [31:0] cmd;
      logic [31:0] arg;
      logic [127:0] resp;
      logic [5:0] resp_idx;
      logic [17:0] mask;
      logic [17:0] raw;
      logic [31:0] fifo_threshold_control;
      logic [31:0] debnce;
      logic [31:0] usr;
      logic [1:0] rstn;
      logic de;
      logic fb;
      logic swr;
      sdh_cmd_state_t st;
      logic [6:0] icnt;
      logic [8:0] sy1;
      logic [8:0] sy2;
      logic ck_prev;
      logic [1:0] cd_prev;
      logic [31:0] rdata;
      logic issue;
      logic poll;
      logic cmd_line;
   } sdh_state_t;
endpackage

//--- verilog/sdh_regs.sv
// Command, response, event status and DMA mode register bank of the card host.
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/10ps
`include "sdh_defines.svh"
module sdh_regs
   import sdh_pkg::*;
#(
   parameter int FIFO_DEPTH = 1024,
   parameter int CNT_W = 13,
   parameter bit MMC_ONLY = 1'b0
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic card_clk,
   input wire logic card_data0,
   input wire logic card_data3,
   input wire logic [1:0] card_detect_n,
   input wire logic [1:0] card_wp,
   input wire logic [1:0] card_irq,
   output logic cmd_line_out,
   output logic cmd_line_oe,
   output logic [1:0] card_rst_n,
   output sdh_issue_t cmd_issue,
   output logic cmd_issue_valid,
   input wire logic cmd_sent,
   input wire logic resp_valid,
   input wire logic [5:0] resp_index,
   input wire logic [127:0] resp_data,
   input wire logic [15:0] event_pulse,
   input wire logic data_engine_active,
   input wire logic [CNT_W-1:0] fifo_count,
   input wire logic end_of_packet,
   input wire logic [31:0] card_byte_count,
   input wire logic [31:0] host_byte_count,
   output logic dma_rx_req,
   output logic dma_tx_req,
   output logic dma_single,
   output logic [2:0] dma_burst_code,
   output logic internal_dma_on,
   output logic fixed_burst_select,
   output logic dma_soft_reset,
   output logic descriptor_resume,
   output logic [31:0] debounce_count,
   output logic irq
);
   sdh_state_t q_ff;
   sdh_state_t nxt_q;
   logic wr;
   logic rd;
   logic mapped;
   logic busy_cmd;
   logic [17:0] masked;
   logic [31:0] status;
   logic [CNT_W-1:0] rx_wm;
   logic [CNT_W-1:0] tx_wm;
   logic rx_above;
   logic tx_below;
   logic reading;
   logic writing;
   logic ck_rise;
   logic [17:0] hw_set;

   // Decodes whether an address names an implemented register.
   function automatic logic is_mapped(input logic [7:0] a);
      case (a)
         `SDH_A_INTMASK, `SDH_A_CMDARG, `SDH_A_CMD, `SDH_A_RESP0,
         `SDH_A_RESP1, `SDH_A_RESP2, `SDH_A_RESP3, `SDH_A_MINTSTS,
         `SDH_A_RINTSTS, `SDH_A_STATUS, `SDH_A_FIFO_THRESHOLD_CONTROL, `SDH_A_CDETECT,
         `SDH_A_WRTPRT, `SDH_A_TCBCNT, `SDH_A_TBBCNT, `SDH_A_DEBNCE,
         `SDH_A_USRID, `SDH_A_RSTCARD, `SDH_A_BMOD, `SDH_A_POLL: is_mapped = 1'b1;
         default: is_mapped = 1'b0;
      endcase
   endfunction

   // Access phase completes in the first access cycle; unmapped addresses answer an error.
   assign pready = 1'b1;
   assign mapped = is_mapped(paddr);
   assign pslverr = psel & penable & ~mapped;
   assign wr = psel & penable & pwrite & mapped;
   assign rd = psel & ~penable & ~pwrite;
   assign busy_cmd = q_ff.cmd[`SDH_B_START];

   // Watermark comparisons, not qualified by transfer activity.
   // The receive level stops below the burst-size field, so the two never share a bit.
   assign rx_wm = CNT_W'(q_ff.fifo_threshold_control[27:16]);
   assign tx_wm = q_ff.fifo_threshold_control[0 +: CNT_W];
   assign rx_above = fifo_count > rx_wm;
   assign tx_below = fifo_count <= tx_wm;
   assign reading = data_engine_active & ~q_ff.cmd[`SDH_B_WRITE];
   assign writing = data_engine_active & q_ff.cmd[`SDH_B_WRITE];
   // Card clock rising edges are found on the synchronised copy only.
   assign ck_rise = q_ff.sy2[8] & ~q_ff.ck_prev;

   // Masked status and the single interrupt line.
   assign masked = q_ff.raw & q_ff.mask;
   assign irq = |masked;

   // Status word: FIFO count, index, busy flags, line levels, state, FIFO flags.
   always_comb begin
      status = 32'h00000000;
      status[29:17] = 13'(fifo_count);
      status[16:11] = q_ff.resp_idx;
      status[10] = data_engine_active;
      status[9] = ~q_ff.sy2[7];
      status[8] = q_ff.sy2[6];
      status[7:4] = q_ff.st;
      status[3] = 32'(fifo_count) >= FIFO_DEPTH;
      status[2] = fifo_count == '0;
      status[1] = tx_below;
      status[0] = rx_above;
   end

   // Hardware event sources; the card interrupt bits stay zero in the MMC-only build.
   always_comb begin
      hw_set = {2'b00, event_pulse};
      if (!MMC_ONLY) begin
         hw_set[17:16] = q_ff.sy2[1:0];
      end
      if (q_ff.sy2[5:4] != q_ff.cd_prev) begin
         hw_set[`SDH_E_CARDDET] = 1'b1;
      end
      if (reading & rx_above & ~q_ff.de) begin
         hw_set[`SDH_E_RXREQ] = 1'b1;
      end
      if (writing & (tx_below | end_of_packet) & ~q_ff.de) begin
         hw_set[`SDH_E_TXREQ] = 1'b1;
      end
      if (wr & busy_cmd & (paddr == `SDH_A_CMD || paddr == `SDH_A_CMDARG)) begin
         hw_set[`SDH_E_LOCKED] = 1'b1;
      end
      // Command done marks the end of every command, with or without a reply.
      if (q_ff.st == SDH_NCC || (q_ff.st == SDH_RXST && resp_valid)) begin
         hw_set[`SDH_E_CMDDONE] = 1'b1;
      end
   end

   // Next-state logic of the whole bank and of the command engine.
   always_comb begin
      nxt_q = q_ff;
      nxt_q.issue = 1'b0;
      nxt_q.poll = 1'b0;
      nxt_q.swr = 1'b0;
      // Two flip-flops carry every pin level into this clock before any logic reads it.
      nxt_q.sy1 = {card_clk, card_data0, card_data3, card_detect_n, card_wp, card_irq};
      nxt_q.sy2 = q_ff.sy1;
      nxt_q.ck_prev = q_ff.sy2[8];
      nxt_q.cd_prev = q_ff.sy2[5:4];
      // Raw events: logged regardless of mask, write one clears, a new event wins.
      nxt_q.raw = q_ff.raw;
      if (wr && paddr == `SDH_A_RINTSTS) begin
         nxt_q.raw = q_ff.raw & ~pwdata[17:0];
      end
      nxt_q.raw = nxt_q.raw | hw_set;
      if (MMC_ONLY) begin
         nxt_q.raw[17:16] = 2'b00;
      end
      // Register writes; command registers are locked while a command is pending.
      if (wr) begin
         case (paddr)
            `SDH_A_INTMASK: nxt_q.mask = MMC_ONLY ? {2'b00, pwdata[15:0]} : pwdata[17:0];
            `SDH_A_CMDARG: if (!busy_cmd) nxt_q.arg = pwdata;
            `SDH_A_CMD: if (!busy_cmd) nxt_q.cmd = pwdata;
            `SDH_A_FIFO_THRESHOLD_CONTROL: nxt_q.fifo_threshold_control = pwdata;
            `SDH_A_DEBNCE: nxt_q.debnce = pwdata;
            `SDH_A_USRID: nxt_q.usr = pwdata;
            `SDH_A_RSTCARD: nxt_q.rstn = pwdata[1:0];
            `SDH_A_BMOD: begin
               nxt_q.de = pwdata[`SDH_B_DE];
               nxt_q.fb = pwdata[`SDH_B_FB];
               nxt_q.swr = pwdata[`SDH_B_SWR];
            end
            `SDH_A_POLL: nxt_q.poll = 1'b1;
            default: nxt_q.poll = 1'b0;
         endcase
      end
      // Soft reset clears the DMA mode bits it owns.
      if (q_ff.swr) begin
         nxt_q.de = 1'b0;
         nxt_q.fb = 1'b0;
      end
      // Command engine.
      case (q_ff.st)
         SDH_IDLE: begin
            // A command with the wait bit stays here while data still moves.
            if (busy_cmd && !(q_ff.cmd[`SDH_B_WAITPRV] && data_engine_active)) begin
               if (q_ff.cmd[`SDH_B_INIT]) begin
                  nxt_q.st = SDH_INIT;
                  nxt_q.icnt = 7'd0;
                  nxt_q.cmd_line = 1'b1;
               end else begin
                  nxt_q.st = SDH_TXST;
                  nxt_q.issue = 1'b1;
               end
            end
         end
         SDH_INIT: begin
            if (ck_rise) begin
               nxt_q.icnt = q_ff.icnt + 7'd1;
               if (q_ff.icnt == `SDH_INIT_CLKS - 7'd1) begin
                  nxt_q.st = SDH_TXST;
                  nxt_q.cmd_line = 1'b0;
                  nxt_q.issue = 1'b1;
               end
            end
         end
         SDH_TXST: begin
            if (cmd_sent) begin
               nxt_q.cmd[`SDH_B_START] = 1'b0;
               nxt_q.st = q_ff.cmd[`SDH_B_REXP] ? SDH_RXST : SDH_NCC;
            end
         end
         SDH_RXST: begin
            // A reply timeout or reply error ends the wait without a reply.
            if (resp_valid) begin
               nxt_q.st = SDH_NCC;
               nxt_q.resp_idx = resp_index;
               if (q_ff.cmd[`SDH_B_RLONG]) begin
                  nxt_q.resp = resp_data;
               end else begin
                  nxt_q.resp[31:0] = resp_data[31:0];
               end
            end else if (event_pulse[`SDH_E_RTO] || event_pulse[`SDH_E_RESPERR]) begin
               nxt_q.st = SDH_NCC;
            end
         end
         SDH_NCC: nxt_q.st = SDH_IDLE;
         default: nxt_q.st = SDH_IDLE;
      endcase
      // Read data is captured in the setup phase, so it is stable in the access phase.
      nxt_q.rdata = 32'h00000000;
      if (rd) begin
         case (paddr)
            `SDH_A_INTMASK: nxt_q.rdata = {14'h0000, q_ff.mask};
            `SDH_A_CMDARG: nxt_q.rdata = q_ff.arg;
            `SDH_A_CMD: nxt_q.rdata = q_ff.cmd;
            `SDH_A_RESP0: nxt_q.rdata = q_ff.resp[31:0];
            `SDH_A_RESP1: nxt_q.rdata = q_ff.resp[63:32];
            `SDH_A_RESP2: nxt_q.rdata = q_ff.resp[95:64];
            `SDH_A_RESP3: nxt_q.rdata = q_ff.resp[127:96];
            `SDH_A_MINTSTS: nxt_q.rdata = {14'h0000, masked};
            `SDH_A_RINTSTS: nxt_q.rdata = {14'h0000, q_ff.raw};
            `SDH_A_STATUS: nxt_q.rdata = status;
            `SDH_A_FIFO_THRESHOLD_CONTROL: nxt_q.rdata = q_ff.fifo_threshold_control;
            `SDH_A_CDETECT: nxt_q.rdata = {30'h00000000, q_ff.sy2[5:4]};
            `SDH_A_WRTPRT: nxt_q.rdata = {30'h00000000, q_ff.sy2[3:2]};
            `SDH_A_TCBCNT: nxt_q.rdata = card_byte_count;
            `SDH_A_TBBCNT: nxt_q.rdata = host_byte_count;
            `SDH_A_DEBNCE: nxt_q.rdata = q_ff.debnce;
            `SDH_A_USRID: nxt_q.rdata = q_ff.usr;
            `SDH_A_RSTCARD: nxt_q.rdata = {30'h00000000, q_ff.rstn};
            `SDH_A_BMOD: begin
               nxt_q.rdata[10:8] = q_ff.fifo_threshold_control[30:28];
               nxt_q.rdata[`SDH_B_DE] = q_ff.de;
               nxt_q.rdata[`SDH_B_FB] = q_ff.fb;
            end
            default: nxt_q.rdata = 32'h00000000;
         endcase
      end
   end

   // State register; the command register starts clear, the card resets start released.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q_ff <= '0;
         q_ff.resp <= {4{`SDH_RST_WORD}};
         q_ff.rstn <= `SDH_RST_CARDRST;
         q_ff.st <= SDH_IDLE;
         // Detect synchronisers start at the no-card level, so release raises no false event.
         q_ff.sy1[5:4] <= `SDH_RST_DETECT;
         q_ff.sy2[5:4] <= `SDH_RST_DETECT;
         q_ff.cd_prev <= `SDH_RST_DETECT;
      end else begin
         q_ff <= nxt_q;
      end
   end

   // Command hand-off: data options are dropped when no data phase follows.
   always_comb begin
      cmd_issue.index = q_ff.cmd[5:0];
      cmd_issue.arg = q_ff.arg;
      cmd_issue.resp_exp = q_ff.cmd[`SDH_B_REXP];
      cmd_issue.resp_long = q_ff.cmd[`SDH_B_RLONG];
      cmd_issue.crc_check = q_ff.cmd[`SDH_B_CRCCHK] & q_ff.cmd[`SDH_B_REXP];
      cmd_issue.data_exp = q_ff.cmd[`SDH_B_DATAEXP];
      cmd_issue.write = q_ff.cmd[`SDH_B_WRITE] & q_ff.cmd[`SDH_B_DATAEXP];
      cmd_issue.stream = q_ff.cmd[`SDH_B_TMODE] & q_ff.cmd[`SDH_B_DATAEXP];
      cmd_issue.auto_stop = q_ff.cmd[`SDH_B_AUTOSTOP] & q_ff.cmd[`SDH_B_DATAEXP];
      cmd_issue.stop_abort = q_ff.cmd[`SDH_B_STOPAB];
      cmd_issue.card = q_ff.cmd[20:16];
   end
   assign cmd_issue_valid = q_ff.issue;
   assign cmd_line_out = q_ff.cmd_line;
   assign cmd_line_oe = q_ff.cmd_line;

   // DMA requests: threshold requests, with single transfers flushing at end of packet.
   assign dma_rx_req = q_ff.de & reading & (rx_above | end_of_packet);
   assign dma_tx_req = q_ff.de & writing & (tx_below | end_of_packet);
   // Single transfers flush the residue left at end of packet.
   assign dma_single = q_ff.de & data_engine_active & end_of_packet;
   assign dma_burst_code = q_ff.fifo_threshold_control[30:28];
   assign internal_dma_on = q_ff.de;
   assign fixed_burst_select = q_ff.fb;
   assign dma_soft_reset = q_ff.swr;
   assign descriptor_resume = q_ff.poll;
   // Plain register copies seen by the rest of the controller.
   assign debounce_count = q_ff.debnce;
   assign card_rst_n = q_ff.rstn;
   assign prdata = q_ff.rdata;
endmodule
